/* core/dpr_cfg.svh */
// Sizes, field positions and reset values of the dual-port memory block
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
`define DPR_TOTAL_BITS 4608
`define DPR_ROWS 128
`define DPR_ROW_AW 7
`define DPR_ROW_W 36
`define DPR_NP_ROW_W 32
`define DPR_ADDR_W 12
`define DPR_DATA_W 36
`define DPR_MASK_W 4
`define DPR_TAPS_W 6
`define DPR_SHIFT_LEN_W 18
`define DPR_CAP_W 24
`define DPR_LANE8 8
`define DPR_LANE9 9
`define DPR_ADDR_RST 12'h000
`define DPR_DATA_RST 36'h000000000
`define DPR_MASK_RST 4'h0
`endif

/* core/dpr_pkg.sv */
// Types and width decoders shared by the dual-port memory block
`default_nettype none
package dpr_pkg;
  // Operating modes of the block
  typedef enum logic [2:0] {
    DPR_TDP, DPR_SDP, DPR_SP, DPR_FIFO, DPR_ROM, DPR_SHIFT
  } dpr_mode_e;
  // Port organisations, depth follows from the width
  typedef enum logic [3:0] {
    DPR_X1, DPR_X2, DPR_X4, DPR_X8, DPR_X9,
    DPR_X16, DPR_X18, DPR_X32, DPR_X36
  } dpr_width_e;

  // Data bits per word for an organisation
  function automatic logic [5:0] dpr_width_bits(dpr_width_e w);
    case (w)
      DPR_X1: return 6'h01;
      DPR_X2: return 6'h02;
      DPR_X4: return 6'h04;
      DPR_X8: return 6'h08;
      DPR_X9: return 6'h09;
      DPR_X16: return 6'h10;
      DPR_X18: return 6'h12;
      DPR_X32: return 6'h20;
      default: return 6'h24;
    endcase
  endfunction

  // Widths that use the parity-position bits
  function automatic logic dpr_is_parity(dpr_width_e w);
    return w inside {DPR_X9, DPR_X18, DPR_X36};
  endfunction

  // Widths that honour the byte mask
  function automatic logic dpr_has_mask(dpr_width_e w);
    return w inside {DPR_X16, DPR_X18, DPR_X32, DPR_X36};
  endfunction

  // Widest organisations, not usable with two read/write ports
  function automatic logic dpr_is_widest(dpr_width_e w);
    return w inside {DPR_X32, DPR_X36};
  endfunction
endpackage
`default_nettype wire

/* core/dpr_map_if.sv */
// Word-to-row mapping signals between the core and a lane mapper
`include "dpr_cfg.svh"
`default_nettype none
interface dpr_map_if;
  import dpr_pkg::*;
  dpr_width_e width;
  logic [`DPR_ADDR_W-1:0] addr;
  logic [`DPR_MASK_W-1:0] mask;
  logic [`DPR_DATA_W-1:0] wdata;
  logic [`DPR_ROW_W-1:0] rdrow;
  logic [`DPR_ROW_AW-1:0] row;
  logic [`DPR_ROW_W-1:0] colmask;
  logic [`DPR_ROW_W-1:0] rowdata;
  logic [`DPR_DATA_W-1:0] rdata;
  modport mapper (input width, addr, mask, wdata, rdrow,
                  output row, colmask, rowdata, rdata);
  modport core (output width, addr, mask, wdata, rdrow,
                input row, colmask, rowdata, rdata);
endinterface
`default_nettype wire

/* core/dpr_lane_map.sv */
// Places one port word into its storage row and picks it back out
`include "dpr_cfg.svh"
`default_nettype none
module dpr_lane_map (
  // Word side and row side of one port
  dpr_map_if.mapper m
);
  import dpr_pkg::*;

  // Plain widths skip every ninth column, so parity bits stay untouched
  always_comb begin
    int w;
    int lim;
    int off;
    int lane;
    int l;
    int j;
    logic par;
    par = dpr_is_parity(m.width);
    w = int'(dpr_width_bits(m.width));
    lim = par ? `DPR_ROW_W : `DPR_NP_ROW_W;
    lane = par ? `DPR_LANE9 : `DPR_LANE8;
    off = (int'(m.addr) * w) % lim;
    l = 0;
    j = 0;
    // Out-of-range addresses wrap inside the block
    m.row = `DPR_ROW_AW'((int'(m.addr) * w) / lim);
    m.colmask = '0;
    m.rowdata = '0;
    m.rdata = '0;
    for (int c = 0; c < `DPR_ROW_W; c++) begin
      l = par ? c : c - c / `DPR_LANE9;
      j = l - off;
      if ((par || (c % `DPR_LANE9) != `DPR_LANE9 - 1) && j >= 0 &&
          j < w) begin
        m.colmask[c] = dpr_has_mask(m.width) ? m.mask[j / lane] : 1'b1;
        m.rowdata[c] = m.wdata[j];
        m.rdata[j] = m.rdrow[c];
      end
    end
  end
endmodule // dpr_lane_map
`default_nettype wire

/* core/dpr_cfg_check.sv */
// Legality check of the chosen mode and port organisations
`include "dpr_cfg.svh"
`default_nettype none
module dpr_cfg_check (
  // Configuration
  input wire dpr_pkg::dpr_mode_e mode_i,
  input wire dpr_pkg::dpr_width_e width_a_i,
  input wire dpr_pkg::dpr_width_e width_b_i,
  input wire logic [`DPR_ADDR_W-1:0] tap_len_i,
  input wire logic [`DPR_TAPS_W-1:0] tap_cnt_i,
  // Verdict
  output logic cfg_ok_o
);
  import dpr_pkg::*;
  logic [`DPR_CAP_W-1:0] shift_bits;
  logic same_family;

  // Width times tap length times tap count of the shift register
  assign shift_bits = `DPR_CAP_W'(dpr_width_bits(width_a_i)) *
                      `DPR_CAP_W'(tap_len_i) * `DPR_CAP_W'(tap_cnt_i);
  assign same_family = dpr_is_parity(width_a_i) == dpr_is_parity(width_b_i);

  // Illegal setups block every write so memory contents stay intact
  always_comb begin
    case (mode_i)
      DPR_TDP: cfg_ok_o = same_family && !dpr_is_widest(width_a_i) &&
                          !dpr_is_widest(width_b_i);
      DPR_SDP, DPR_FIFO: cfg_ok_o = same_family;
      DPR_SHIFT: cfg_ok_o = shift_bits != '0 &&
                            shift_bits <= `DPR_CAP_W'(`DPR_TOTAL_BITS);
      default: cfg_ok_o = 1'b1;
    endcase
  end
endmodule // dpr_cfg_check
`default_nettype wire

/* core/dpr_top.sv */
// Dual-port 4608-bit memory block with mixed widths and byte masks
//
// Overview of operation
// - Storage holds 4608 bits including parity bits.
// - Modes: two-port, simple, single, FIFO, ROM, shift.
// - RAM and ROM contents preload at configuration.
// - Organisations from 4096x1 up to 128x36.
// - No 128-deep words with two read/write ports.
// - Simple mode mixes widths within one family.
// - Two-port mode mixes widths within one family.
// - Shift width times length times taps fits.
// - Byte mask only at 16/18/32/36 write width.
// - Masked bytes keep their old contents.
// - Mask bits map to nine-bit lanes upward at 18/36.
// - Any mix of mask bits is accepted.
// - Plain 16/32 widths use eight-bit lanes.
// - Input and output registers pick either clock, except port B inputs in shift mode.
// - Only the output register may be bypassed.
// - Each port has clock, enable, renwe, clear.
// - Input clear empties registers at the next clock edge.
// - Output clear shows on the output at once.
// - Bytes carry one extra parity bit only at 9/18/36 widths.
`include "dpr_cfg.svh"
`default_nettype none
module dpr_top #(
  parameter logic [`DPR_TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Block configuration
  input wire dpr_pkg::dpr_mode_e mode_i,
  input wire dpr_pkg::dpr_width_e width_a_i,
  input wire dpr_pkg::dpr_width_e width_b_i,
  input wire logic [1:0] in_clk_sel_i,
  input wire logic [1:0] out_clk_sel_i,
  input wire logic [1:0] out_reg_en_i,
  input wire logic [`DPR_ADDR_W-1:0] tap_len_i,
  input wire logic [`DPR_TAPS_W-1:0] tap_cnt_i,
  // Port controls, index 0 is port A and index 1 is port B
  input wire logic [1:0] clken_i,
  input wire logic [1:0] renwe_i,
  input wire logic [1:0] clr_i,
  input wire logic [1:0][`DPR_ADDR_W-1:0] addr_i,
  input wire logic [1:0][`DPR_MASK_W-1:0] byte_mask_i,
  input wire logic [1:0][`DPR_DATA_W-1:0] wdata_i,
  // Results
  output logic [1:0][`DPR_DATA_W-1:0] rdata_o,
  output logic cfg_ok_o
);
  import dpr_pkg::*;

  // 128 rows of four nine-bit lanes
  logic [`DPR_ROW_W-1:0] mem [`DPR_ROWS];
  logic [1:0] in_en;
  logic [1:0] out_en;
  logic [1:0] can_wr;
  logic [1:0] can_rd;
  logic [1:0] we;
  logic [1:0] cap;
  logic [1:0] ren_q;
  logic [1:0] ren_d;
  logic [1:0] go_q;
  logic [1:0] go_d;
  logic [1:0][`DPR_ADDR_W-1:0] addr_q;
  logic [1:0][`DPR_ADDR_W-1:0] addr_d;
  logic [1:0][`DPR_MASK_W-1:0] mask_q;
  logic [1:0][`DPR_MASK_W-1:0] mask_d;
  logic [1:0][`DPR_DATA_W-1:0] wd_q;
  logic [1:0][`DPR_DATA_W-1:0] wd_d;
  logic [1:0][`DPR_DATA_W-1:0] out_q;
  logic [1:0][`DPR_DATA_W-1:0] out_d;
  logic [`DPR_ROW_AW-1:0] row [2];
  logic [`DPR_ROW_W-1:0] cm [2];
  logic [`DPR_ROW_W-1:0] rowdat [2];
  logic [`DPR_ROW_W-1:0] wrow [2];
  logic [`DPR_DATA_W-1:0] rd [2];
  dpr_width_e wid [2];
  logic [`DPR_ADDR_W-1:0] ptr_q;
  logic [`DPR_ADDR_W-1:0] ptr_d;
  logic [`DPR_SHIFT_LEN_W-1:0] shift_len;
  logic shift_mode;

  dpr_cfg_check u_check (
    .mode_i(mode_i),
    .width_a_i(width_a_i),
    .width_b_i(width_b_i),
    .tap_len_i(tap_len_i),
    .tap_cnt_i(tap_cnt_i),
    .cfg_ok_o(cfg_ok_o)
  );

  // port widths; shift mode reads back at the write width
  assign shift_mode = mode_i == DPR_SHIFT;
  assign wid[0] = width_a_i;
  assign wid[1] = shift_mode ? width_a_i : width_b_i;
  assign shift_len = `DPR_SHIFT_LEN_W'(tap_len_i) *
                     `DPR_SHIFT_LEN_W'(tap_cnt_i);

  // which port may write or read in each mode
  always_comb begin
    case (mode_i)
      DPR_TDP: begin
        can_wr = 2'h3;
        can_rd = 2'h3;
      end
      DPR_SP: begin
        can_wr = 2'h1;
        can_rd = 2'h1;
      end
      DPR_ROM: begin
        can_wr = 2'h0;
        can_rd = 2'h3;
      end
      default: begin
        can_wr = 2'h1;
        can_rd = 2'h2;
      end
    endcase
  end

  // each register group follows the chosen port's clock; port B inputs follow port A's in shift mode
  assign in_en[0] = clken_i[in_clk_sel_i[0]];
  assign in_en[1] = shift_mode ? in_en[0] : clken_i[in_clk_sel_i[1]];
  assign out_en[0] = clken_i[out_clk_sel_i[0]];
  assign out_en[1] = clken_i[out_clk_sel_i[1]];

  // Input registers of both ports, never bypassed
  always_comb begin
    ren_d = ren_q;
    addr_d = addr_q;
    mask_d = mask_q;
    wd_d = wd_q;
    go_d = 2'h0;
    for (int p = 0; p < 2; p++) begin
      if (clr_i[p]) begin
        ren_d[p] = 1'b0;
        addr_d[p] = `DPR_ADDR_RST;
        mask_d[p] = `DPR_MASK_RST;
        wd_d[p] = `DPR_DATA_RST;
      end else if (in_en[p]) begin
        ren_d[p] = renwe_i[p];
        addr_d[p] = addr_i[p];
        mask_d[p] = byte_mask_i[p];
        wd_d[p] = wdata_i[p];
        go_d[p] = 1'b1;
        if (shift_mode) begin
          // port A writes and port B reads the same slot
          ren_d[p] = p == 0;
          addr_d[p] = ptr_q;
        end
      end
    end
  end

  // Shift slot pointer wraps after tap length times tap count words
  always_comb begin
    ptr_d = ptr_q;
    if (!shift_mode) begin
      ptr_d = `DPR_ADDR_RST;
    end else if (in_en[0] && !clr_i[0]) begin
      if (`DPR_SHIFT_LEN_W'(ptr_q) + 1'b1 >= shift_len) begin
        ptr_d = `DPR_ADDR_RST;
      end else begin
        ptr_d = ptr_q + 1'b1;
      end
    end
  end

  // Input register and pointer state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ren_q <= 2'h0;
      go_q <= 2'h0;
      addr_q <= '0;
      mask_q <= '0;
      wd_q <= '0;
      ptr_q <= `DPR_ADDR_RST;
    end else begin
      ren_q <= ren_d;
      go_q <= go_d;
      addr_q <= addr_d;
      mask_q <= mask_d;
      wd_q <= wd_d;
      ptr_q <= ptr_d;
    end
  end

  // One lane mapper per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    dpr_map_if mp ();
    assign mp.width = wid[p];
    assign mp.addr = addr_q[p];
    assign mp.mask = mask_q[p];
    assign mp.wdata = wd_q[p];
    assign mp.rdrow = mem[mp.row];
    assign row[p] = mp.row;
    assign cm[p] = mp.colmask;
    assign rowdat[p] = mp.rowdata;
    assign rd[p] = mp.rdata;
    dpr_lane_map u_map (
      .m(mp)
    );
  end

  // a captured high renwe writes one cycle later
  assign we = go_q & ren_q & can_wr & {2{cfg_ok_o}};

  // merge masked lanes; port B wins on overlap
  always_comb begin
    wrow[0] = (mem[row[0]] & ~cm[0]) | (rowdat[0] & cm[0]);
    wrow[1] = (((we[0] && row[0] == row[1]) ? wrow[0] : mem[row[1]]) &
               ~cm[1]) | (rowdat[1] & cm[1]);
  end

  // reset loads the preset image, then writes land
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int r = 0; r < `DPR_ROWS; r++) begin
        mem[r] <= INIT_IMAGE[r*`DPR_ROW_W +: `DPR_ROW_W];
      end
    end else begin
      if (we[0]) begin
        mem[row[0]] <= wrow[0];
      end
      if (we[1]) begin
        mem[row[1]] <= wrow[1];
      end
    end
  end

  // Output register loads the flow-through word of a read port
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      cap[p] = out_en[p] && !ren_q[p] && can_rd[p];
      out_d[p] = clr_i[p] ? `DPR_DATA_RST : (cap[p] ? rd[p] : out_q[p]);
    end
  end

  // Output register state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  // bypass choice; clear forces zero at once
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (clr_i[p]) begin
        rdata_o[p] = `DPR_DATA_RST;
      end else begin
        rdata_o[p] = out_reg_en_i[p] ? out_q[p] : rd[p];
      end
    end
  end

  // Helper state that remembers the last lone port A write
  logic chk_v_q;
  logic [`DPR_ROW_AW-1:0] chk_row_q;
  logic [`DPR_ROW_W-1:0] chk_val_q;
  always_ff @(posedge clk_i) begin
    chk_v_q <= we[0] && !(we[1] && row[1] == row[0]);
    chk_row_q <= row[0];
    chk_val_q <= wrow[0];
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_rom_no_write;
    (mode_i == DPR_ROM) |-> (we == 2'h0);
  endproperty
  a_rom_no_write: assert property (p_rom_no_write)
    else $error("write happened in ROM mode");

  property p_write_lands;
    chk_v_q |-> (mem[chk_row_q] == chk_val_q);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("port A write did not reach its row");

  property p_enable_low_idle;
    (!in_en[0] && !clr_i[0]) |=> (!go_q[0] && $stable(addr_q[0]));
  endproperty
  a_enable_low_idle: assert property (p_enable_low_idle)
    else $error("port A acted with its clock enable low");

  property p_in_clear;
    clr_i[1] |=> (addr_q[1] == `DPR_ADDR_RST && !go_q[1] && !ren_q[1]);
  endproperty
  a_in_clear: assert property (p_in_clear)
    else $error("input clear left port B registers set");

  property p_out_clear;
    clr_i[0] |-> (rdata_o[0] == `DPR_DATA_RST);
  endproperty
  a_out_clear: assert property (p_out_clear)
    else $error("output clear not seen at once");

  property p_out_reg_holds;
    (out_reg_en_i[1] && !clr_i[1] && !cap[1]) ##1
      (out_reg_en_i[1] && !clr_i[1]) |-> $stable(rdata_o[1]);
  endproperty
  a_out_reg_holds: assert property (p_out_reg_holds)
    else $error("registered output moved without a load");

  property p_tdp_widest;
    (mode_i == DPR_TDP && dpr_is_widest(width_a_i)) |-> !cfg_ok_o;
  endproperty
  a_tdp_widest: assert property (p_tdp_widest)
    else $error("widest words accepted with two ports");

  property p_family_mix;
    (mode_i inside {DPR_TDP, DPR_SDP} &&
     dpr_is_parity(width_a_i) != dpr_is_parity(width_b_i)) |-> !cfg_ok_o;
  endproperty
  a_family_mix: assert property (p_family_mix)
    else $error("parity and plain widths mixed");

  property p_mask_lane0;
    (wid[0] == DPR_X18 && !mask_q[0][0]) |-> (cm[0][8:0] == 9'h000);
  endproperty
  a_mask_lane0: assert property (p_mask_lane0)
    else $error("masked lane zero still enabled");

  property p_shift_ptr;
    (shift_mode && cfg_ok_o) |->
      (`DPR_SHIFT_LEN_W'(ptr_q) < shift_len);
  endproperty
  a_shift_ptr: assert property (p_shift_ptr)
    else $error("shift pointer past its length");
endmodule // dpr_top
`default_nettype wire

/* testbench/dpr_fabric.sv */
// Fabric-side driver model that works the two memory ports
`include "dpr_cfg.svh"
`default_nettype none
module dpr_fabric (
  // Clock
  input wire logic clk_i,
  // Port controls toward the memory, index 0 is port A
  output logic [1:0] clken_o,
  output logic [1:0] renwe_o,
  output logic [1:0] clr_o,
  output logic [1:0][`DPR_ADDR_W-1:0] addr_o,
  output logic [1:0][`DPR_MASK_W-1:0] mask_o,
  output logic [1:0][`DPR_DATA_W-1:0] wdata_o,
  // Read data from the memory
  input wire logic [1:0][`DPR_DATA_W-1:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle ports at time zero, nothing requested
  initial begin
    clken_o = 2'h0;
    renwe_o = 2'h0;
    clr_o = 2'h0;
    addr_o = '0;
    mask_o = '0;
    wdata_o = '0;
  end

  // Let go of a port; stale lines are inverted so nothing relies on them
  task automatic idle(input int p);
    clken_o[p] <= 1'b0;
    renwe_o[p] <= 1'b0;
    addr_o[p] <= ~addr_o[p];
    mask_o[p] <= ~mask_o[p];
    wdata_o[p] <= ~wdata_o[p];
  endtask

  task automatic wr(input int p, input logic en, input logic [11:0] a,
                    input logic [3:0] m, input logic [35:0] d);
    @(posedge clk_i);
    clken_o[p] <= en;
    renwe_o[p] <= 1'b1;
    addr_o[p] <= a;
    mask_o[p] <= m;
    wdata_o[p] <= d;
    @(posedge clk_i);
    idle(p);
  endtask

  // low renwe reads; enable stays up for the output load
  task automatic rd(input int p, input logic [11:0] a,
                    output logic [35:0] d);
    @(posedge clk_i);
    clken_o[p] <= 1'b1;
    renwe_o[p] <= 1'b0;
    addr_o[p] <= a;
    @(posedge clk_i);
    @(posedge clk_i);
    idle(p);
    #1;
    d = rdata_i[p];
  endtask

  // Per-port clear level
  task automatic clear(input int p, input logic v);
    @(posedge clk_i);
    clr_o[p] <= v;
  endtask
endmodule // dpr_fabric
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the dual-port memory block
`include "dpr_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dpr_pkg::*;

  // One setup and the verdict it should get
  typedef struct packed {
    dpr_mode_e md;
    dpr_width_e a;
    dpr_width_e b;
    logic [11:0] len;
    logic [5:0] cnt;
    logic ok;
  } dpr_row_s;

  logic clk;
  logic rst_b;
  dpr_mode_e mode;
  dpr_width_e wa;
  dpr_width_e wb;
  logic [1:0] in_sel, out_sel, oreg, clken, renwe, clr;
  logic [11:0] tlen;
  logic [5:0] tcnt;
  logic [1:0][`DPR_ADDR_W-1:0] addr;
  logic [1:0][`DPR_MASK_W-1:0] mask;
  logic [1:0][`DPR_DATA_W-1:0] wdata, rdata;
  logic cfg_ok;
  logic [35:0] d, exp;
  int mismatches = 0;
  int n_tests = 0;

  // Setup table, shift rows sit at the capacity edge
  dpr_row_s rows [12] = '{
    '{DPR_TDP, DPR_X32, DPR_X32, 12'h000, 6'h00, 1'b0},
    '{DPR_TDP, DPR_X16, DPR_X1, 12'h000, 6'h00, 1'b1},
    '{DPR_TDP, DPR_X9, DPR_X18, 12'h000, 6'h00, 1'b1},
    '{DPR_TDP, DPR_X8, DPR_X9, 12'h000, 6'h00, 1'b0},
    '{DPR_SDP, DPR_X32, DPR_X1, 12'h000, 6'h00, 1'b1},
    '{DPR_SDP, DPR_X36, DPR_X9, 12'h000, 6'h00, 1'b1},
    '{DPR_SDP, DPR_X36, DPR_X32, 12'h000, 6'h00, 1'b0},
    '{DPR_SP, DPR_X36, DPR_X36, 12'h000, 6'h00, 1'b1},
    '{DPR_FIFO, DPR_X8, DPR_X8, 12'h000, 6'h00, 1'b1},
    '{DPR_ROM, DPR_X18, DPR_X18, 12'h000, 6'h00, 1'b1},
    '{DPR_SHIFT, DPR_X1, DPR_X1, 12'h480, 6'h04, 1'b1},
    '{DPR_SHIFT, DPR_X1, DPR_X1, 12'h481, 6'h04, 1'b0}
  };

  dpr_top u_dut (
    .clk_i(clk), .rst_b_i(rst_b), .mode_i(mode), .width_a_i(wa),
    .width_b_i(wb), .in_clk_sel_i(in_sel), .out_clk_sel_i(out_sel),
    .out_reg_en_i(oreg), .tap_len_i(tlen), .tap_cnt_i(tcnt),
    .clken_i(clken), .renwe_i(renwe), .clr_i(clr), .addr_i(addr),
    .byte_mask_i(mask), .wdata_i(wdata), .rdata_o(rdata),
    .cfg_ok_o(cfg_ok)
  );

  dpr_fabric u_fab (
    .clk_i(clk), .clken_o(clken), .renwe_o(renwe), .clr_o(clr),
    .addr_o(addr), .mask_o(mask), .wdata_o(wdata), .rdata_i(rdata)
  );

  // Clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [35:0] got, input logic [35:0] want,
                     input string what);
    n_tests++;
    if (got !== want) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, want);
    end
  endtask

  // Counts, verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Mode and widths change only while both ports are idle
  task automatic setw(input dpr_mode_e md, input dpr_width_e a,
                      input dpr_width_e b);
    @(posedge clk);
    mode <= md;
    wa <= a;
    wb <= b;
    tlen <= 12'h000;
    tcnt <= 6'h00;
  endtask

  // Expected word after a masked write with lanes of lw bits
  function automatic logic [35:0] merge(input logic [35:0] old,
      input logic [35:0] nw, input logic [3:0] m, input int lw);
    logic [35:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < lw; b++) begin
        if (m[k]) begin
          r[k*lw+b] = nw[k*lw+b];
        end
      end
    end
    return r;
  endfunction

  // Hang guard: a stuck run still ends in the report
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("[ERR] %0t run did not finish", $time);
    conclude();
  end

  // Main sequence
  initial begin
    mode = DPR_SDP;
    wa = DPR_X36;
    wb = DPR_X36;
    in_sel = 2'h2;
    out_sel = 2'h2;
    oreg = 2'h3;
    tlen = 12'h000;
    tcnt = 6'h00;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    u_fab.rd(1, 12'h005, d);
    chk(d, 36'h000000000, "preload");
    foreach (rows[i]) begin
      @(posedge clk);
      mode <= rows[i].md;
      wa <= rows[i].a;
      wb <= rows[i].b;
      tlen <= rows[i].len;
      tcnt <= rows[i].cnt;
      @(negedge clk);
      chk({35'h0, cfg_ok}, {35'h0, rows[i].ok}, "setup");
    end
    // every mask mix on nine-bit lanes
    setw(DPR_SDP, DPR_X36, DPR_X36);
    exp = 36'h123456789;
    u_fab.wr(0, 1'b1, 12'h006, 4'hF, exp);
    for (int m = 0; m < 16; m++) begin
      u_fab.wr(0, 1'b1, 12'h006, m[3:0], {9{m[3:0]}});
      exp = merge(exp, {9{m[3:0]}}, m[3:0], 9);
      u_fab.rd(1, 12'h006, d);
      chk(d, exp, "masked x36");
    end
    // no write while the enable is low
    u_fab.wr(0, 1'b0, 12'h006, 4'hF, 36'h000000000);
    u_fab.rd(1, 12'h006, d);
    chk(d, exp, "enable low");
    setw(DPR_ROM, DPR_X36, DPR_X36);
    u_fab.wr(0, 1'b1, 12'h006, 4'hF, 36'h000000000);
    u_fab.rd(1, 12'h006, d);
    chk(d, exp, "rom write");
    // clear forces the output at once
    u_fab.clear(1, 1'b1);
    #1;
    chk(rdata[1], 36'h000000000, "clear");
    u_fab.clear(1, 1'b0);
    setw(DPR_SDP, DPR_X32, DPR_X32);
    u_fab.wr(0, 1'b1, 12'h007, 4'hF, 36'h0AABBCCDD);
    u_fab.wr(0, 1'b1, 12'h007, 4'h2, 36'h011223344);
    u_fab.rd(1, 12'h007, d);
    chk(d, 36'h0AABB33DD, "x32 lanes");
    setw(DPR_SDP, DPR_X8, DPR_X8);
    u_fab.wr(0, 1'b1, 12'h003, 4'h0, 36'h00000005A);
    u_fab.rd(1, 12'h003, d);
    chk(d, 36'h00000005A, "x8 no mask");
    // wide write read back as bytes
    setw(DPR_SDP, DPR_X32, DPR_X8);
    u_fab.wr(0, 1'b1, 12'h000, 4'hF, 36'h087654321);
    u_fab.rd(1, 12'h000, d);
    chk(d, 36'h000000021, "mixed low");
    u_fab.rd(1, 12'h003, d);
    chk(d, 36'h000000087, "mixed high");
    // port B writes, port A reads
    setw(DPR_TDP, DPR_X16, DPR_X16);
    u_fab.wr(1, 1'b1, 12'h002, 4'hF, 36'h00000BEEF);
    u_fab.rd(0, 12'h002, d);
    chk(d, 36'h00000BEEF, "two ports");
    // port A clear hides its registered word at once
    u_fab.clear(0, 1'b1);
    #1;
    chk(rdata[0], 36'h000000000, "clear A");
    u_fab.clear(0, 1'b0);
    // bypassed output still gives the word
    @(posedge clk);
    oreg <= 2'h1;
    u_fab.rd(1, 12'h002, d);
    chk(d, 36'h00000BEEF, "bypass");
    // bypassed word follows memory while port B stays idle
    u_fab.wr(0, 1'b1, 12'h002, 4'hF, 36'h000001234);
    @(posedge clk);
    #1;
    chk(rdata[1], 36'h000001234, "bypass follows");
    // port B inputs follow the port A enable, so B's own is ignored
    @(posedge clk);
    in_sel <= 2'h0;
    u_fab.rd(1, 12'hFFD, d);
    chk(d, 36'h000001234, "input clock select");
    conclude();
  end
endmodule // testbench
`default_nettype wire
